// ### ees_ctrl.sv
// Two-wire bus controller model for the serial memory slave
`timescale 1ns/100ps
`default_nettype none

module ees_ctrl (
	// Bench clock
	input wire logic clock,
	// Bus
	output logic scl,
	output logic pull_low,
	input wire logic sda
);
	// Clock high, data released between frames
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end

	// ----------------------------------------
	// Bit level, 4 clocks a half period
	// ----------------------------------------
	task automatic hp(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Data moves a clock after scl falls, so it never looks like a start
	task automatic xbit(input logic b, output logic v);
		hp(1);
		pull_low = ~b;
		hp(3);
		scl = 1'b1;
		hp(4);
		v = sda;
		scl = 1'b0;
	endtask

	task automatic start();
		hp(1);
		pull_low = 1'b0;
		hp(3);
		scl = 1'b1;
		hp(4);
		pull_low = 1'b1;
		hp(4);
		scl = 1'b0;
	endtask

	task automatic stop();
		hp(1);
		pull_low = 1'b1;
		hp(3);
		scl = 1'b1;
		hp(4);
		pull_low = 1'b0;
		hp(4);
	endtask

	// Nine clocks let a slave stuck mid-byte run out its byte and drop off
	task automatic recover();
		logic v;
		start();
		repeat (9) begin
			xbit(1'b1, v);
		end
		start();
		stop();
	endtask

	// ----------------------------------------
	// Byte level, MSB first
	// ----------------------------------------
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], v);
		end
		xbit(1'b1, v);
		ack = ~v;
	endtask

	// Ack asks for one more byte; no ack ends the read
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'b1, v);
			d[i] = v;
		end
		xbit(~more, v);
	endtask
endmodule
`default_nettype wire

// ### ees_params.svh
// Constants for the two-wire serial memory slave
`ifndef EES_PARAMS_SVH
`define EES_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define EES_CLK_PERIOD_NS 20
`define EES_T_WR_MS 5
// Longest time, so rounded down
`define EES_T_WR_CYC ((`EES_T_WR_MS * 1000000) / `EES_CLK_PERIOD_NS)
`define EES_TMR_W 18

// ----------------------------------------
// Addressing
// ----------------------------------------
`define EES_DEV_CODE 4'hA
// 13 for 8192 bytes, 12 for 4096 bytes
`define EES_ADDR_W 13
`define EES_PAGE_W 5
`define EES_PAGE_BYTES 32
`define EES_PAGES (1 << (`EES_ADDR_W - `EES_PAGE_W))
`define EES_BYTE_BITS 4'h8

`endif

// ### ees_pkg.sv
// Types for the two-wire serial memory slave
`include "ees_params.svh"

package ees_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_AHI,
		ST_ALO,
		ST_WDAT,
		ST_RD,
		ST_BUSY
	} ees_state_e;

	typedef logic [`EES_ADDR_W-1:0] ees_addr_t;
	typedef logic [`EES_TMR_W-1:0] ees_tmr_t;

	// Pins that cross into the clock domain
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] strap;
	} ees_pins_s;

	typedef struct packed {
		ees_pins_s sync1;
		ees_pins_s sync2;
		logic scl_d;
		logic sda_d;
		ees_state_e st;
		logic [3:0] bcnt;
		logic ackph;
		logic rw;
		logic mack;
		logic got;
		logic busy;
		logic sda_o;
		logic sda_oe;
		logic [7:0] shreg;
		logic [7:0] ahi;
		ees_addr_t aptr;
		logic [`EES_PAGE_BYTES-1:0] mask;
		logic [`EES_PAGE_BYTES-1:0][7:0] pbuf;
		ees_tmr_t tmr;
	} ees_state_s;

endpackage

// ### ees_slave.sv
// Two-wire serial memory slave: protocol engine, page buffer and array
// What this block does
// - Device address word must carry the 1010 pattern in its top four bits.
// - Next three bits must equal the three strap inputs exactly.
// - Unconnected strap inputs count as logic low; this block adds no pull-down, straps are used as driven.
// - Eighth address bit picks the operation: one reads, zero writes.
// - Acknowledge a matching address; on mismatch release and return to standby.
// - Write protect high inhibits all array writes; low lets them proceed.
// - Write takes two word address bytes then data, each acknowledged.
// - From stop to end of programming ignore all inputs, never acknowledge.
// - Page write takes up to 32 bytes, each acknowledged.
// - Writes increment only the low 5 address bits, wrapping in the page.
// - Over 32 bytes wrap and overwrite bytes loaded earlier.
// - Address polling gets an acknowledge only after programming ends.
// - Address counter holds last address plus one between operations.
// - Read address wraps from last byte of memory to the first.
// - Current address read shifts out the byte at the counter.
// - Each controller acknowledge advances the counter and sends another byte.
// - Bytes are 8 bits; receiver drives zero on the ninth clock.
// - Data falling with clock high is start, rising is stop.
`timescale 1ns/100ps
`default_nettype none
`include "ees_params.svh"

module ees_slave #(
	parameter int WR_CYCLES = `EES_T_WR_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Straps and protection
	input wire logic strap_addr_bit2,
	input wire logic strap_addr_bit1,
	input wire logic strap_addr_bit0,
	input wire logic wp_in,
	// Status
	output logic write_busy
);
	import ees_pkg::*;

	// ----------------------------------------
	// State and edge detection
	// ----------------------------------------
	ees_state_s s;
	ees_state_s next_s;
	ees_pins_s pins;
	logic rise;
	logic fall;
	logic start_ev;
	logic stop_ev;
	logic match;
	logic commit;
	logic byte_done;
	logic [7:0] rd_byte;
	logic [7:0] rd_bank [`EES_PAGE_BYTES];

	// Straps go straight to the sync stage; nothing here pulls floating ones low
	assign pins = '{scl: scl_in, sda: sda_in, wp: wp_in,
		strap: {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}};

	// Edges only from the second sync stage
	assign rise = s.sync2.scl & ~s.scl_d;
	assign fall = ~s.sync2.scl & s.scl_d;
	assign start_ev = s.scl_d & s.sync2.scl & s.sda_d & ~s.sync2.sda;
	assign stop_ev = s.scl_d & s.sync2.scl & ~s.sda_d & s.sync2.sda;
	assign match = (s.shreg[7:4] == `EES_DEV_CODE) && (s.shreg[3:1] == s.sync2.strap);
	assign commit = (s.st == ST_BUSY) && (s.tmr == ees_tmr_t'(WR_CYCLES - 1));
	assign byte_done = fall && !s.ackph && (s.bcnt == `EES_BYTE_BITS) && !start_ev && !stop_ev;
	assign rd_byte = rd_bank[s.aptr[`EES_PAGE_W-1:0]];

	// ----------------------------------------
	// Array, one bank per byte of a page
	// ----------------------------------------
	// Whole page lands in one cycle, so no per-byte sequencing in the write cycle
	for (genvar i = 0; i < `EES_PAGE_BYTES; i++) begin : g_bank
		logic [7:0] bank [`EES_PAGES];
		always_ff @(posedge clock) begin
			if (commit && s.mask[i]) begin
				bank[s.aptr[`EES_ADDR_W-1:`EES_PAGE_W]] <= s.pbuf[i];
			end
		end
		assign rd_bank[i] = bank[s.aptr[`EES_ADDR_W-1:`EES_PAGE_W]];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic ld;
		ld = 1'b0;
		next_s = s;
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		next_s.scl_d = s.sync2.scl;
		next_s.sda_d = s.sync2.sda;
		if (s.st == ST_BUSY) begin
			// Deaf to the bus, so polling sees no acknowledge
			next_s.sda_oe = 1'b0;
			next_s.tmr = s.tmr + 1'b1;
			if (commit) begin
				next_s.st = ST_IDLE;
			end
		end else if (start_ev) begin
			// Half-received byte is simply dropped
			next_s.st = ST_DEV;
			next_s.bcnt = 4'h0;
			next_s.ackph = 1'b0;
			next_s.sda_oe = 1'b0;
			next_s.got = 1'b0;
		end else if (stop_ev) begin
			next_s.sda_oe = 1'b0;
			next_s.ackph = 1'b0;
			next_s.tmr = '0;
			// Only whole data bytes count; protect pin blocks programming
			if (s.st == ST_WDAT && s.got && !s.sync2.wp) begin
				next_s.st = ST_BUSY;
			end else begin
				next_s.st = ST_IDLE;
			end
		end else if (s.st != ST_IDLE) begin
			if (rise) begin
				if (s.ackph) begin
					next_s.mack = ~s.sync2.sda;
				end else begin
					next_s.bcnt = s.bcnt + 4'h1;
					if (s.st != ST_RD) begin
						next_s.shreg = {s.shreg[6:0], s.sync2.sda};
					end
				end
			end else if (fall && s.ackph) begin
				next_s.ackph = 1'b0;
				next_s.bcnt = 4'h0;
				next_s.sda_oe = 1'b0;
				unique case (s.st)
					ST_DEV: begin
						if (s.rw) begin
							ld = 1'b1;
						end else begin
							next_s.st = ST_AHI;
						end
					end
					ST_AHI: next_s.st = ST_ALO;
					ST_ALO: next_s.st = ST_WDAT;
					ST_WDAT: ;
					ST_RD: begin
						if (s.mack) begin
							ld = 1'b1;
						end else begin
							next_s.st = ST_IDLE;
						end
					end
					ST_IDLE, ST_BUSY: ;
				endcase
			end else if (byte_done) begin
				next_s.sda_oe = 1'b1;
				next_s.ackph = 1'b1;
				unique case (s.st)
					ST_DEV: begin
						if (match) begin
							next_s.rw = s.shreg[0];
						end else begin
							next_s.sda_oe = 1'b0;
							next_s.ackph = 1'b0;
							next_s.st = ST_IDLE;
						end
					end
					ST_AHI: next_s.ahi = s.shreg;
					ST_ALO: begin
						// Top bits beyond the array drop here
						next_s.aptr = ees_addr_t'({s.ahi, s.shreg});
						next_s.mask = '0;
					end
					ST_WDAT: begin
						// Wrap and overwrite within the page
						next_s.pbuf[s.aptr[`EES_PAGE_W-1:0]] = s.shreg;
						next_s.mask[s.aptr[`EES_PAGE_W-1:0]] = 1'b1;
						next_s.aptr[`EES_PAGE_W-1:0] = s.aptr[`EES_PAGE_W-1:0] + 1'b1;
						next_s.got = 1'b1;
					end
					ST_RD: begin
						// Release so the controller can answer
						next_s.sda_oe = 1'b0;
						next_s.mack = 1'b0;
					end
					ST_IDLE, ST_BUSY: ;
				endcase
			end else if (fall && s.st == ST_RD && s.bcnt != 4'h0 && !s.ackph) begin
				next_s.shreg = {s.shreg[6:0], 1'b0};
				next_s.sda_oe = ~s.shreg[6];
			end
		end
		if (ld) begin
			// Counter keeps last address plus one, full wrap
			next_s.st = ST_RD;
			next_s.shreg = rd_byte;
			next_s.sda_oe = ~rd_byte[7];
			next_s.aptr = s.aptr + 1'b1;
		end
		next_s.sda_o = 1'b0;
		next_s.busy = (next_s.st == ST_BUSY);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sda_out = s.sda_o;
	assign sda_oe = s.sda_oe;
	assign write_busy = s.busy;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	property p_code_reject;
		s.st == ST_DEV && byte_done && s.shreg[7:4] != `EES_DEV_CODE
			|=> !s.sda_oe && s.st == ST_IDLE;
	endproperty
	a_code_reject: assert property (p_code_reject) else $error("bad code acked");

	property p_strap_reject;
		s.st == ST_DEV && byte_done && s.shreg[3:1] != s.sync2.strap |=> !s.sda_oe [*2];
	endproperty
	a_strap_reject: assert property (p_strap_reject) else $error("strap mismatch acked");

	property p_addr_ack;
		s.st == ST_DEV && byte_done && match |=> s.sda_oe && s.ackph;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("match not acked");

	property p_rw_select;
		s.st == ST_DEV && s.ackph && fall && !start_ev && !stop_ev
			|=> s.st == ($past(s.rw) ? ST_RD : ST_AHI);
	endproperty
	a_rw_select: assert property (p_rw_select) else $error("wrong direction");

	property p_busy_quiet;
		s.st == ST_BUSY |-> !s.sda_oe;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");

	property p_poll_nack;
		s.busy && start_ev && !commit |=> s.st == ST_BUSY ##1 !s.sda_oe;
	endproperty
	a_poll_nack: assert property (p_poll_nack) else $error("poll acked while busy");

	property p_wp_block;
		stop_ev && s.st == ST_WDAT && s.sync2.wp |=> !s.busy && s.st == ST_IDLE;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("write under protect");

	property p_page_inc;
		s.st == ST_WDAT && byte_done
			|=> s.aptr == {$past(s.aptr[`EES_ADDR_W-1:`EES_PAGE_W]),
			$past(s.aptr[`EES_PAGE_W-1:0]) + 5'h01};
	endproperty
	a_page_inc: assert property (p_page_inc) else $error("page address step");

	property p_read_inc;
		s.st == ST_RD && s.ackph && fall && s.mack && !start_ev && !stop_ev
			|=> s.aptr == $past(s.aptr) + 1'b1 && s.sda_oe == ~s.shreg[7];
	endproperty
	a_read_inc: assert property (p_read_inc) else $error("read step");

	property p_partial_drop;
		s.st == ST_WDAT && start_ev |=> s.mask == $past(s.mask) && s.st == ST_DEV;
	endproperty
	a_partial_drop: assert property (p_partial_drop) else $error("partial byte kept");

	c_ack: cover property (s.st == ST_DEV && byte_done && match);
	c_prog: cover property ($rose(s.busy) ##[1:300] s.busy);
	c_seq_read: cover property (s.st == ST_RD && s.ackph && fall && s.mack);
	c_wrap: cover property (s.st == ST_WDAT && byte_done && s.aptr[4:0] == 5'h1F);

endmodule
`default_nettype wire

// ### test_ees_slave.sv
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/100ps
`default_nettype none

module test_ees_slave;
	import ees_pkg::*;
	localparam logic [7:0] DEV_W = 8'hAA;
	localparam logic [7:0] DEV_R = 8'hAB;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic wp_in = 1'b0;
	logic [2:0] strap = 3'h5;
	logic sda_out, sda_oe, write_busy, scl, pull_low;
	wire logic sda;
	int miscompares = 0;
	int tests_run = 0;
	logic bit_v;

	// Pull-up: released line reads high
	assign sda = (sda_oe ? sda_out : 1'b1) & ~pull_low;

	initial begin
		forever #10 clock = ~clock;
	end

	// Short write cycle keeps the run brief, still longer than one poll
	ees_slave #(.WR_CYCLES(200)) dut_u (.clock(clock), .arst_n(arst_n), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .strap_addr_bit2(strap[2]),
		.strap_addr_bit1(strap[1]), .strap_addr_bit0(strap[0]), .wp_in(wp_in),
		.write_busy(write_busy));
	ees_ctrl ctrl_u (.clock(clock), .scl(scl), .pull_low(pull_low), .sda(sda));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic dev(input logic [7:0] db, input logic exp);
		logic a;
		ctrl_u.start();
		ctrl_u.wbyte(db, a);
		chk({7'h0, a}, {7'h0, exp});
	endtask

	task automatic wdata(input logic [7:0] d);
		logic a;
		ctrl_u.wbyte(d, a);
		chk({7'h0, a}, 8'h01);
	endtask

	task automatic set_addr(input logic [15:0] ad);
		dev(DEV_W, 1'b1);
		wdata(ad[15:8]);
		wdata(ad[7:0]);
	endtask

	task automatic rd(input logic more, input logic [7:0] exp);
		logic [7:0] d;
		ctrl_u.rbyte(more, d);
		chk(d, exp);
	endtask

	// Bounded: a stuck busy flag ends the run
	task automatic wait_idle();
		int n;
		n = 0;
		while (write_busy !== 1'b0 && n < 400) begin
			@(negedge clock);
			n++;
		end
		if (n == 400) begin
			miscompares++;
			$display("[FAIL] %0t write cycle never ended", $time);
			wrap_up();
		end
	endtask

	task automatic end_write(input logic exp_busy);
		ctrl_u.stop();
		chk({7'h0, write_busy}, {7'h0, exp_busy});
		wait_idle();
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(negedge clock);
		arst_n = 1'b1;
		repeat (4) @(negedge clock);
		dev(8'hA8, 1'b0);
		ctrl_u.stop();
		dev(8'hBA, 1'b0);
		ctrl_u.stop();
		set_addr(16'hE000);
		wdata(8'hD0);
		ctrl_u.stop();
		chk({7'h0, write_busy}, 8'h01);
		dev(DEV_W, 1'b0);
		ctrl_u.stop();
		wait_idle();
		set_addr(16'h1FFF);
		wdata(8'h11);
		wdata(8'h22);
		wdata(8'h33);
		end_write(1'b1);
		set_addr(16'h1FFF);
		dev(DEV_R, 1'b1);
		rd(1'b1, 8'h11);
		rd(1'b0, 8'hD0);
		ctrl_u.stop();
		set_addr(16'h1FE0);
		dev(DEV_R, 1'b1);
		rd(1'b0, 8'h22);
		ctrl_u.stop();
		dev(DEV_R, 1'b1);
		rd(1'b0, 8'h33);
		ctrl_u.stop();
		set_addr(16'h1FE0);
		for (int i = 0; i < 33; i++) begin
			wdata(i[7:0]);
		end
		end_write(1'b1);
		set_addr(16'h1FE0);
		dev(DEV_R, 1'b1);
		rd(1'b1, 8'h20);
		rd(1'b0, 8'h01);
		ctrl_u.stop();
		wp_in = 1'b1;
		set_addr(16'h1FE1);
		wdata(8'h99);
		end_write(1'b0);
		set_addr(16'h1FE1);
		dev(DEV_R, 1'b1);
		rd(1'b0, 8'h01);
		ctrl_u.stop();
		wp_in = 1'b0;
		set_addr(16'h1FE3);
		wdata(8'h5A);
		repeat (3) ctrl_u.xbit(1'b0, bit_v);
		end_write(1'b1);
		set_addr(16'h1FE3);
		dev(DEV_R, 1'b1);
		rd(1'b1, 8'h5A);
		rd(1'b0, 8'h04);
		ctrl_u.stop();
		dev(DEV_R, 1'b1);
		repeat (2) ctrl_u.xbit(1'b1, bit_v);
		chk({7'h0, bit_v}, 8'h00);
		ctrl_u.recover();
		dev(DEV_R, 1'b1);
		rd(1'b0, 8'h06);
		ctrl_u.stop();
		wrap_up();
	end
endmodule
`default_nettype wire
